// ==== design/dac_port_pkg.sv ====
// Purpose: Shared constants for the converter write-port host controller
// Assumes: 25 MHz mclk, 40 ns period
// Notes: Pin timing minimums are rounded up to whole clock cycles; the host gives setup one cycle, not SETUP_CYC
package dac_port_pkg;
  localparam int DATA_W = 16;
  localparam int MSB_POS = 15;
  localparam int LSB_POS = 0;
  localparam int CLK_PERIOD_NS = 40;
  localparam int SETUP_NS = 50;
  localparam int HOLD_NS = 10;
  localparam int WRITE_NS = 50;
  localparam int WRITE_SINGLE_NS = 80;
  localparam int CLEAR_NS = 200;
  localparam int SETUP_CYC = (SETUP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int HOLD_CYC = (HOLD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int WRITE_CYC = (WRITE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int WRITE_SINGLE_CYC = (WRITE_SINGLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int CLEAR_CYC = (CLEAR_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int CNT_W = 4;
  localparam logic [15:0] CODE_POS_FULL = 16'h7fff;
  localparam logic [15:0] CODE_NEG_FULL = 16'h8000;
  localparam logic [15:0] CODE_ZERO = 16'h0000;
  localparam logic [1:0] OP_LOAD = 2'h0;
  localparam logic [1:0] OP_UPDATE = 2'h1;
  localparam logic [1:0] OP_BOTH = 2'h2;
  localparam logic [1:0] OP_CLEAR = 2'h3;
endpackage

// ==== design/pulse_timer.sv ====
// Purpose: Down-counter that marks when a programmed number of cycles has passed
// Assumes: load and ce come from mclk logic
// Notes: done is high while the count is zero
module pulse_timer #(
  parameter int W = 4
) (
  input wire logic mclk,
  input wire logic rst,
  input wire logic ce,
  input wire logic load,
  input wire logic [W-1:0] value,
  output logic done
);
  typedef struct packed {
    logic [W-1:0] count;
  } timer_state_t;
  timer_state_t st_reg;
  timer_state_t st_next;
  always_comb begin
    st_next = st_reg;
    if (load) begin
      st_next.count = value;
    end else if (st_reg.count != '0) begin
      st_next.count = st_reg.count - 1'b1;
    end
  end
  always_ff @(posedge mclk) begin
    if (rst) begin
      st_reg <= '0;
    end else if (ce) begin
      st_reg <= st_next;
    end
  end
  // Done must not look at load: the host loads on done, and that would loop
  assign done = (st_reg.count == '0);
endmodule

// ==== design/dac_bus_host.sv ====
// Purpose: Host that drives the converter's 16-bit double-buffered write port
// Assumes: One request at a time; cmdReady high means a request is taken
// Notes: All pin outputs are registered; control pins idle high
//////////////////////////////////////////////////////////////////////////////
// Functional notes
// - All control pins driven active low
// - Data bit 15 is most significant
// - Words are two's complement codes
// - Load inputs first, then update together
// - Strobe low 50 ns, 80 ns single-buffered
module dac_bus_host #(
  parameter int DATA_WIDTH = dac_port_pkg::DATA_W
) (
  input wire logic mclk,
  input wire logic rst,
  input wire logic ce,
  input wire logic cmdValid,
  input wire logic [1:0] cmdOp,
  input wire logic [DATA_WIDTH-1:0] cmdData,
  output logic cmdReady,
  output logic busy,
  output logic [DATA_WIDTH-1:0] dataBus,
  output logic writeStrobeN,
  output logic inputLatchSelN,
  output logic outputLatchSelN,
  output logic zeroOutputN
);
  typedef enum {S_IDLE, S_SETUP, S_STROBE, S_HOLD, S_CLEAR} host_state_t;
  typedef struct packed {
    host_state_t fsm;
    logic [DATA_WIDTH-1:0] data;
    logic wrN;
    logic inSelN;
    logic outSelN;
    logic clrN;
    logic single;
  } host_t;
  host_t st_reg;
  host_t st_next;
  logic timerLoad;
  logic [dac_port_pkg::CNT_W-1:0] timerValue;
  logic timerDone;

  // One shared down-counter times the strobe, the hold and the clear in turn
  pulse_timer #(.W(dac_port_pkg::CNT_W)) u_timer (
    .mclk(mclk),
    .rst(rst),
    .ce(ce),
    .load(timerLoad),
    .value(timerValue),
    .done(timerDone)
  );

  function automatic logic [1:0] selsFor(input logic [1:0] op);
    // Returns {outSelN, inSelN}
    case (op)
      dac_port_pkg::OP_LOAD: selsFor = 2'b10;
      dac_port_pkg::OP_UPDATE: selsFor = 2'b01;
      dac_port_pkg::OP_BOTH: selsFor = 2'b00;
      default: selsFor = 2'b11;
    endcase
  endfunction

  // Ready is combinational so a request is taken on the first free edge
  assign cmdReady = (st_reg.fsm == S_IDLE) && ce;

  //////////////////////////////////////////////////////////////////////////////
  // Request decode and pin sequencing; pins change only on an enabled edge or on a reset edge
  always_comb begin
    st_next = st_reg;
    timerLoad = 1'b0;
    timerValue = '0;
    case (st_reg.fsm)
      S_IDLE: begin
        if (cmdValid) begin
          if (cmdOp == dac_port_pkg::OP_CLEAR) begin
            // Clear ignores the data word; both latches go to bipolar zero
            st_next.clrN = 1'b0;
            timerLoad = 1'b1;
            timerValue = dac_port_pkg::CNT_W'(dac_port_pkg::CLEAR_CYC - 1);
            st_next.fsm = S_CLEAR;
          end else begin
            // MSB of the word lands on pin bit 15, two's complement as given
            st_next.data = cmdData;
            {st_next.outSelN, st_next.inSelN} = selsFor(cmdOp);
            st_next.single = (cmdOp == dac_port_pkg::OP_BOTH);
            timerLoad = 1'b1;
            timerValue = '0;
            st_next.fsm = S_SETUP;
          end
        end
      end
      S_SETUP: begin
        // Selects and data settle one cycle ahead of the strobe edge
        st_next.wrN = 1'b0;
        timerLoad = 1'b1;
        timerValue = st_reg.single ?
            dac_port_pkg::CNT_W'(dac_port_pkg::WRITE_SINGLE_CYC - 1) :
            dac_port_pkg::CNT_W'(dac_port_pkg::WRITE_CYC - 1);
        st_next.fsm = S_STROBE;
      end
      S_STROBE: begin
        if (timerDone) begin
          // Rising strobe closes the latch; selects and data stay a hold cycle
          st_next.wrN = 1'b1;
          timerLoad = 1'b1;
          timerValue = dac_port_pkg::CNT_W'(dac_port_pkg::HOLD_CYC - 1);
          st_next.fsm = S_HOLD;
        end
      end
      S_HOLD: begin
        if (timerDone) begin
          // Both selects rise together once the latch is already closed
          st_next.inSelN = 1'b1;
          st_next.outSelN = 1'b1;
          st_next.fsm = S_IDLE;
        end
      end
      S_CLEAR: begin
        if (timerDone) begin
          // Clear width is counted in enabled cycles, so a frozen enable stretches it
          st_next.clrN = 1'b1;
          st_next.fsm = S_IDLE;
        end
      end
      default: st_next.fsm = S_IDLE;
    endcase
  end

  // Every control pin is actively driven high when idle, so a floating
  // (asserted) level never reaches the converter
  always_ff @(posedge mclk) begin
    if (rst) begin
      st_reg.fsm <= S_IDLE;
      st_reg.data <= '0;
      st_reg.wrN <= 1'b1;
      st_reg.inSelN <= 1'b1;
      st_reg.outSelN <= 1'b1;
      st_reg.clrN <= 1'b1;
      st_reg.single <= 1'b0;
    end else if (ce) begin
      st_reg <= st_next;
    end
  end

  assign busy = (st_reg.fsm != S_IDLE);
  assign dataBus = st_reg.data;
  assign writeStrobeN = st_reg.wrN;
  assign inputLatchSelN = st_reg.inSelN;
  assign outputLatchSelN = st_reg.outSelN;
  assign zeroOutputN = st_reg.clrN;

  //////////////////////////////////////////////////////////////////////////////
  // Low-time counter for the strobe, used by the assertions below
  logic [3:0] wrLowCnt;
  always_ff @(posedge mclk) begin
    if (rst) begin
      wrLowCnt <= '0;
    end else if (ce) begin
      wrLowCnt <= writeStrobeN ? 4'h0 : wrLowCnt + 4'h1;
    end
  end

  // Low time is counted in enabled cycles only, so a frozen enable stretches
  // the strobe without tripping these checks
  AST_WR_MIN: assert property (@(posedge mclk) disable iff (rst)
    $rose(writeStrobeN) |-> wrLowCnt >= 4'(dac_port_pkg::WRITE_CYC))
    else $error("write strobe low too short");

  AST_WR_SINGLE: assert property (@(posedge mclk) disable iff (rst)
    ($rose(writeStrobeN) && !outputLatchSelN && !inputLatchSelN) |->
    wrLowCnt >= 4'(dac_port_pkg::WRITE_SINGLE_CYC))
    else $error("single-buffered strobe too short");
  AST_SEL_DURING_WR: assert property (@(posedge mclk) disable iff (rst)
    !writeStrobeN |-> (!inputLatchSelN || !outputLatchSelN))
    else $error("strobe low with no select");
  AST_SEL_HOLD: assert property (@(posedge mclk) disable iff (rst)
    ($rose(writeStrobeN) && ce) |-> ($stable(inputLatchSelN) && $stable(outputLatchSelN)))
    else $error("select changed at strobe release");
  AST_DATA_STABLE: assert property (@(posedge mclk) disable iff (rst)
    !writeStrobeN |-> $stable(dataBus))
    else $error("data moved during strobe");

  // Clear is a command of its own and never overlaps a write
  AST_CLEAR_WIDTH: assert property (@(posedge mclk) disable iff (rst || !ce)
    $fell(zeroOutputN) |-> !zeroOutputN [*5])
    else $error("clear pulse too short");
  AST_CLEAR_ISOLATED: assert property (@(posedge mclk) disable iff (rst)
    !zeroOutputN |-> (writeStrobeN && inputLatchSelN && outputLatchSelN))
    else $error("write activity during clear");
  AST_IDLE_HIGH: assert property (@(posedge mclk) disable iff (rst)
    !busy |-> (writeStrobeN && zeroOutputN && inputLatchSelN && outputLatchSelN))
    else $error("control pin low while idle");
  AST_SETUP: assert property (@(posedge mclk) disable iff (rst || !ce)
    $fell(writeStrobeN) |->
    ($past(inputLatchSelN) == 1'b0 || $past(outputLatchSelN) == 1'b0))
    else $error("select not set up before strobe");

  // Selects open one enabled cycle after the strobe closes the latch
  AST_SEL_RELEASE: assert property (@(posedge mclk) disable iff (rst || !ce)
    ($rose(writeStrobeN) && ce) |=> (inputLatchSelN && outputLatchSelN))
    else $error("select held past the hold cycle");
  AST_DATA_HOLD: assert property (@(posedge mclk) disable iff (rst)
    $rose(writeStrobeN) |-> $stable(dataBus))
    else $error("data moved as the strobe closed");

  // Main scenarios: load, update, single-buffered write, clear, frozen enable
  COV_LOAD: cover property (@(posedge mclk)
    $fell(writeStrobeN) && !inputLatchSelN && outputLatchSelN);
  COV_UPDATE: cover property (@(posedge mclk)
    $fell(writeStrobeN) && inputLatchSelN && !outputLatchSelN);
  COV_BOTH: cover property (@(posedge mclk)
    $fell(writeStrobeN) && !inputLatchSelN && !outputLatchSelN);
  COV_CLEAR: cover property (@(posedge mclk) $rose(zeroOutputN));
  COV_FROZEN: cover property (@(posedge mclk) !ce && !writeStrobeN);
endmodule

// ==== testbench/dac_latch_model.sv ====
// Purpose: Behavioural converter latch pair driven by the host pins
// Assumes: Pins come straight from the host, no board delay
// Notes: widthErr flags a short write or clear pulse
module dac_latch_model (
  input wire logic [15:0] dataPins,
  input wire logic writeStrobeN,
  input wire logic inputLatchSelN,
  input wire logic outputLatchSelN,
  input wire logic zeroOutputN,
  output logic [15:0] inWord,
  output logic [15:0] outWord,
  output logic widthErr
);
  timeunit 1ns;
  timeprecision 1ps;
  // Start far back so the power-up edge is not taken for a short pulse
  realtime wrFall = -1.0e3;
  realtime clrFall = -1.0e3;
  initial widthErr = 1'b0;
  //////////////////////////////////////////////////////////////////////////////
  always_latch begin
    if (!zeroOutputN) inWord <= 16'h0000;
    else if (!writeStrobeN && !inputLatchSelN) inWord <= dataPins;
  end
  always_latch begin
    if (!zeroOutputN) outWord <= 16'h0000;
    else if (!writeStrobeN && !outputLatchSelN) outWord <= inWord;
  end
  always @(negedge writeStrobeN) wrFall = $realtime;
  always @(negedge zeroOutputN) clrFall = $realtime;
  // Single-buffered writes need the longer pulse
  always @(posedge writeStrobeN) begin
    if ($realtime - wrFall < ((inputLatchSelN | outputLatchSelN) ? 50.0 : 80.0)) widthErr = 1'b1;
  end
  always @(posedge zeroOutputN) begin
    if ($realtime - clrFall < 200.0) widthErr = 1'b1;
  end
endmodule

// ==== testbench/dac_double_buffer_bus_port_test.sv ====
// Purpose: Self-checking bench for the converter write-port host
// Assumes: Op codes 0 load, 1 update, 2 both, 3 clear
// Notes: Latch contents are judged through the behavioural model
module dac_double_buffer_bus_port_test;
  timeunit 1ns;
  timeprecision 1ps;
  typedef struct {logic [1:0] op; logic [15:0] d, expIn, expOut;} row_t;
  logic mclk = 1'b0, rst = 1'b1, ce = 1'b1, cmdValid = 1'b0;
  logic [1:0] cmdOp = 2'h0;
  logic [15:0] cmdData = 16'h0000;
  logic cmdReady, busy, writeStrobeN, inputLatchSelN, outputLatchSelN, zeroOutputN, widthErr;
  logic [15:0] dataBus, inWord, outWord;
  int errors = 0, checkCount = 0;
  row_t rows [8] = '{'{2'h3, 16'hffff, 16'h0000, 16'h0000},
    '{2'h0, 16'h7fff, 16'h7fff, 16'h0000}, '{2'h1, 16'h0000, 16'h7fff, 16'h7fff},
    '{2'h0, 16'h8000, 16'h8000, 16'h7fff}, '{2'h1, 16'hffff, 16'h8000, 16'h8000},
    '{2'h2, 16'h1234, 16'h1234, 16'h1234}, '{2'h3, 16'h5555, 16'h0000, 16'h0000},
    '{2'h2, 16'h0001, 16'h0001, 16'h0001}};
  //////////////////////////////////////////////////////////////////////////////
  dac_bus_host dac_bus_host_inst (.mclk(mclk), .rst(rst), .ce(ce), .cmdValid(cmdValid),
    .cmdOp(cmdOp), .cmdData(cmdData), .cmdReady(cmdReady), .busy(busy), .dataBus(dataBus),
    .writeStrobeN(writeStrobeN), .inputLatchSelN(inputLatchSelN),
    .outputLatchSelN(outputLatchSelN), .zeroOutputN(zeroOutputN));
  dac_latch_model dac_latch_model_inst (.dataPins(dataBus), .writeStrobeN(writeStrobeN),
    .inputLatchSelN(inputLatchSelN), .outputLatchSelN(outputLatchSelN),
    .zeroOutputN(zeroOutputN), .inWord(inWord), .outWord(outWord), .widthErr(widthErr));
  initial begin
    forever #20 mclk = ~mclk;
  end
  //////////////////////////////////////////////////////////////////////////////
  task automatic check(input string name, input logic [15:0] seen, input logic [15:0] exp);
    checkCount++;
    if (seen !== exp) begin
      errors++;
      $display("[ERR] %s expected %h seen %h", name, exp, seen);
    end
  endtask
  task automatic giveVerdict;
    if (errors == 0 && checkCount > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  task automatic waitIdle;
    int n;
    for (n = 0; n < 40 && (busy !== 1'b0 || cmdReady !== 1'b1); n++) @(negedge mclk);
    if (n == 40) begin
      errors++;
      giveVerdict;
    end
  endtask
  task automatic send(input logic [1:0] op, input logic [15:0] d);
    @(posedge mclk);
    cmdValid <= 1'b1;
    cmdOp <= op;
    cmdData <= d;
    @(negedge mclk);
    waitIdle;
    @(posedge mclk);
    cmdValid <= 1'b0;
    @(negedge mclk);
    waitIdle;
  endtask
  //////////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (8) @(posedge mclk);
    rst <= 1'b0;
    foreach (rows[i]) begin
      send(rows[i].op, rows[i].d);
      check("input latch", inWord, rows[i].expIn);
      check("converter latch", outWord, rows[i].expOut);
      if (rows[i].op != 2'h3) check("data pins", dataBus, rows[i].d);
    end
    // Clear held up while a load runs must not be taken
    @(posedge mclk);
    cmdValid <= 1'b1;
    cmdOp <= 2'h0;
    cmdData <= 16'hc000;
    @(posedge mclk);
    cmdOp <= 2'h3;
    @(negedge mclk);
    check("ready while busy", {15'h0000, cmdReady}, 16'h0000);
    repeat (3) @(posedge mclk);
    cmdValid <= 1'b0;
    @(negedge mclk);
    waitIdle;
    check("refused clear", inWord, 16'hc000);
    check("held output", outWord, 16'h0001);
    // Clock enable dropped in mid-write stretches the pulse
    fork
      send(2'h2, 16'hfffe);
      begin
        repeat (3) @(posedge mclk);
        ce <= 1'b0;
        repeat (4) @(posedge mclk);
        ce <= 1'b1;
      end
    join
    check("frozen write", outWord, 16'hfffe);
    // Reset lands after the selects fall but before the strobe does
    @(posedge mclk);
    cmdValid <= 1'b1;
    cmdOp <= 2'h0;
    cmdData <= 16'h4000;
    @(posedge mclk);
    cmdValid <= 1'b0;
    rst <= 1'b1;
    @(posedge mclk);
    rst <= 1'b0;
    @(negedge mclk);
    check("pins after reset", {11'h000, busy, writeStrobeN, inputLatchSelN,
      outputLatchSelN, zeroOutputN}, 16'h000f);
    check("bus after reset", dataBus, 16'h0000);
    check("aborted load", inWord, 16'hfffe);
    check("pulse widths", {15'h0000, widthErr}, 16'h0000);
    giveVerdict;
  end
endmodule
